// ===== hw/rfcpc_checker.sv
// RF command-parameter checker: identification answer and parameter validation
`timescale 1ns/1ns
`include "rfcpc_params.svh"
module rfcpc_checker
  import rfcpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Stored system values
  input wire logic [15:0] stored_system_code_i,
  input wire logic [63:0] card_identifier_area_i,
  input wire logic [7:0] response_time_params_rd_i,
  input wire logic [7:0] response_time_params_wr_i,
  // Identification request
  input wire logic req_valid_i,
  input wire logic [15:0] req_system_code_i,
  // Identification answer
  output logic id_resp_valid_o,
  output logic [7:0] id_resp_slot_o,
  output logic [63:0] id_resp_card_id_o,
  output logic [63:0] id_resp_time_desc_o,
  // Command parameters in
  input wire logic cmd_start_i,
  input wire logic cmd_is_write_i,
  input wire logic svc_valid_i,
  input wire logic [15:0] svc_code_i,
  input wire logic blk_valid_i,
  input wire logic blk_len3_i,
  input wire logic [7:0] blk_byte0_i,
  input wire logic [7:0] blk_byte1_i,
  input wire logic [7:0] blk_byte2_i,
  input wire logic cmd_end_i,
  // Decoded element out
  output logic blk_out_valid_o,
  output logic [7:0] blk_out_number_o,
  output logic blk_out_tunnel_o,
  output logic blk_out_err_o,
  // Applicable response-time fields
  output logic [1:0] rt_exp_o,
  output logic [2:0] rt_mul_o,
  output logic [2:0] rt_const_o,
  // Command result
  output logic result_valid_o,
  output logic [7:0] status1_o,
  output logic [7:0] status2_o,
  output logic busy_o
);
  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic sc_answers(input logic [15:0] req, input logic [15:0] stored);
    if (req == `RFCPC_SC_WILDCARD) begin
      sc_answers = 1'b1;
    end else if (req == `RFCPC_SC_PARTIAL) begin
      sc_answers = stored[15:8] == `RFCPC_SC_UPPER;
    end else begin
      sc_answers = req == stored;
    end
  endfunction
  function automatic logic [4:0] max_blocks(input logic wr, input logic tun, input logic [4:0] n);
    if (!wr) begin
      max_blocks = tun ? `RFCPC_MAX_BLK_RD_TUN : `RFCPC_MAX_BLK_RD_RF;
    end else begin
      max_blocks = (n <= `RFCPC_WR_SVC_SPLIT) ? `RFCPC_MAX_BLK_WR_LO : `RFCPC_MAX_BLK_WR_HI;
    end
  endfunction
  function automatic logic [4:0] sat_inc(input logic [4:0] v);
    sat_inc = (v == `RFCPC_CNT_SAT) ? v : v + 5'h01;
  endfunction
  // ----------------------------------------
  // Identification answer
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      id_resp_valid_o <= 1'b0;
      id_resp_slot_o <= 8'h00;
      id_resp_card_id_o <= 64'h0000000000000000;
      id_resp_time_desc_o <= 64'h0000000000000000;
    end else begin
      id_resp_valid_o <= req_valid_i && sc_answers(req_system_code_i, stored_system_code_i);
      if (req_valid_i) begin
        // Single-slot answer keeps collision handling out of the tag
        id_resp_slot_o <= `RFCPC_FIRST_SLOT;
        id_resp_card_id_o <= card_identifier_area_i;
        id_resp_time_desc_o <= {`RFCPC_DESC_ONES, `RFCPC_DESC_ONES,
                                `RFCPC_DESC_ZERO, `RFCPC_DESC_ZERO, `RFCPC_DESC_ZERO,
                                response_time_params_rd_i, response_time_params_wr_i,
                                `RFCPC_DESC_ONES};
      end
    end
  end
  // ----------------------------------------
  // Command sequencing
  // ----------------------------------------
  rfcpc_state_t state_q;
  logic is_write_q;
  logic [4:0] svc_cnt_q;
  logic [4:0] blk_cnt_q;
  logic [15:0] svc_first_q;
  logic svc_diff_q;
  logic elem_err_q;
  logic tunnel_q;
  logic mode_mixed_q;
  logic dec_err;
  logic dec_tunnel;
  rfcpc_elem_dec u_dec (
    .len3_i(blk_len3_i),
    .byte0_i(blk_byte0_i),
    .byte2_i(blk_byte2_i),
    .err_o(dec_err),
    .tunnel_o(dec_tunnel)
  );
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= RFCPC_IDLE;
    end else begin
      case (state_q)
        RFCPC_IDLE: if (cmd_start_i) begin
          state_q <= RFCPC_SVC;
        end
        RFCPC_SVC: begin
          if (cmd_end_i) begin
            state_q <= RFCPC_DONE;
          end else if (blk_valid_i) begin
            state_q <= RFCPC_BLK;
          end
        end
        RFCPC_BLK: if (cmd_end_i) begin
          state_q <= RFCPC_DONE;
        end
        RFCPC_DONE: state_q <= RFCPC_IDLE;
        default: state_q <= RFCPC_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // Service list tracking
  // ----------------------------------------
  logic svc_open;
  assign svc_open = (state_q == RFCPC_SVC) && !cmd_end_i;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      is_write_q <= 1'b0;
      svc_cnt_q <= 5'h00;
      svc_first_q <= 16'h0000;
      svc_diff_q <= 1'b0;
    end else if (state_q == RFCPC_IDLE && cmd_start_i) begin
      is_write_q <= cmd_is_write_i;
      svc_cnt_q <= 5'h00;
      svc_diff_q <= 1'b0;
    end else if (svc_open && svc_valid_i) begin
      svc_cnt_q <= sat_inc(svc_cnt_q);
      if (svc_cnt_q == 5'h00) begin
        svc_first_q <= svc_code_i;
      end else if (svc_code_i != svc_first_q) begin
        svc_diff_q <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Block list tracking
  // ----------------------------------------
  logic blk_take;
  assign blk_take = blk_valid_i && !cmd_end_i && (state_q == RFCPC_SVC || state_q == RFCPC_BLK);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blk_cnt_q <= 5'h00;
      elem_err_q <= 1'b0;
      tunnel_q <= 1'b0;
      mode_mixed_q <= 1'b0;
    end else if (state_q == RFCPC_IDLE && cmd_start_i) begin
      blk_cnt_q <= 5'h00;
      elem_err_q <= 1'b0;
      tunnel_q <= 1'b0;
      mode_mixed_q <= 1'b0;
    end else if (blk_take) begin
      blk_cnt_q <= sat_inc(blk_cnt_q);
      elem_err_q <= elem_err_q || dec_err;
      if (blk_cnt_q == 5'h00) begin
        tunnel_q <= dec_tunnel;
      end else if (dec_tunnel != tunnel_q) begin
        // Mixed modes in one list cannot be routed to one target
        mode_mixed_q <= 1'b1;
      end
    end
  end
  // Element result mirrors each taken element one cycle later
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blk_out_valid_o <= 1'b0;
      blk_out_number_o <= 8'h00;
      blk_out_tunnel_o <= 1'b0;
      blk_out_err_o <= 1'b0;
    end else begin
      blk_out_valid_o <= blk_take;
      if (blk_take) begin
        blk_out_number_o <= blk_byte1_i;
        blk_out_tunnel_o <= dec_tunnel;
        blk_out_err_o <= dec_err;
      end
    end
  end
  // ----------------------------------------
  // Response-time fields of the current command
  // ----------------------------------------
  logic [7:0] rt_sel;
  assign rt_sel = is_write_q ? response_time_params_wr_i : response_time_params_rd_i;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rt_exp_o <= 2'h0;
      rt_mul_o <= 3'h0;
      rt_const_o <= 3'h0;
    end else begin
      rt_exp_o <= rt_sel[`RFCPC_RT_EXP_HI:`RFCPC_RT_EXP_LO];
      rt_mul_o <= rt_sel[`RFCPC_RT_MUL_HI:`RFCPC_RT_MUL_LO];
      rt_const_o <= rt_sel[`RFCPC_RT_CON_HI:`RFCPC_RT_CON_LO];
    end
  end
  // ----------------------------------------
  // Result with fixed error priority
  // ----------------------------------------
  logic svc_cnt_bad;
  logic blk_cnt_bad;
  logic [4:0] svc_max;
  assign svc_max = is_write_q ? `RFCPC_MAX_SVC_WRITE : `RFCPC_MAX_SVC_READ;
  assign svc_cnt_bad = (svc_cnt_q == 5'h00) || (svc_cnt_q > svc_max);
  assign blk_cnt_bad = (blk_cnt_q == 5'h00) ||
                       (blk_cnt_q > max_blocks(is_write_q, tunnel_q, svc_cnt_q));
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_valid_o <= 1'b0;
      status1_o <= `RFCPC_ST1_OK;
      status2_o <= `RFCPC_ST2_OK;
    end else begin
      result_valid_o <= state_q == RFCPC_DONE;
      if (state_q == RFCPC_DONE) begin
        status1_o <= `RFCPC_ST1_ERR;
        if (svc_cnt_bad) begin
          status2_o <= `RFCPC_ST2_SVC_CNT;
        end else if (svc_diff_q) begin
          status2_o <= `RFCPC_ST2_SVC_DIFF;
        end else if (elem_err_q || mode_mixed_q) begin
          status2_o <= `RFCPC_ST2_BLK_SPEC;
        end else if (blk_cnt_bad) begin
          status2_o <= `RFCPC_ST2_BLK_CNT;
        end else begin
          status1_o <= `RFCPC_ST1_OK;
          status2_o <= `RFCPC_ST2_OK;
        end
      end
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state_q != RFCPC_IDLE) || cmd_start_i;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_wild_answer: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_valid_i && req_system_code_i == 16'hFFFF |=> id_resp_valid_o)
    else $error("wildcard request not answered");
  chk_partial_answer: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_valid_i && req_system_code_i == 16'hAAFF
    |=> id_resp_valid_o == ($past(stored_system_code_i[15:8]) == 8'hAA))
    else $error("partial wildcard answer wrong");
  chk_exact_match: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_valid_i && req_system_code_i != 16'hFFFF && req_system_code_i != 16'hAAFF
    |=> id_resp_valid_o == ($past(req_system_code_i) == $past(stored_system_code_i)))
    else $error("exact system code answer wrong");
  chk_card_id: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_valid_i ##1 id_resp_valid_o |-> id_resp_card_id_o == $past(card_identifier_area_i))
    else $error("card identifier not carried");
  chk_desc_bytes: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    id_resp_valid_o |-> id_resp_time_desc_o[63:48] == 16'hFFFF &&
    id_resp_time_desc_o[47:24] == 24'h000000 && id_resp_time_desc_o[7:0] == 8'hFF)
    else $error("descriptor fixed bytes wrong");
  chk_desc_params: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_valid_i |=> id_resp_time_desc_o[23:8] ==
    {$past(response_time_params_rd_i), $past(response_time_params_wr_i)})
    else $error("descriptor parameter bytes wrong");
  chk_first_slot: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    id_resp_valid_o |-> id_resp_slot_o == 8'h00)
    else $error("answer not in first slot");
  chk_access_err: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    blk_take && blk_byte0_i[6:4] != 3'h0 |=> blk_out_valid_o && blk_out_err_o)
    else $error("access mode error missed");
  chk_d2_reserved: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    blk_take && blk_len3_i && blk_byte2_i[7:3] != 5'h00 |=> blk_out_err_o)
    else $error("third byte reserved bits missed");
  chk_mode_decode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    blk_take && blk_byte0_i[6:4] == 3'h0 && (!blk_len3_i || blk_byte2_i == 8'h00)
    |=> !blk_out_err_o && !blk_out_tunnel_o)
    else $error("RF mode element misdecoded");
  chk_svc_limit: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == RFCPC_DONE && svc_cnt_q > (is_write_q ? 5'h0B : 5'h0F)
    |=> result_valid_o && status1_o == 8'hFF && status2_o == 8'hA1)
    else $error("service count limit missed");
  chk_svc_diff: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == RFCPC_DONE && !svc_cnt_bad && svc_diff_q |=> status2_o == 8'hA3)
    else $error("service mismatch missed");
  chk_elem_status: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == RFCPC_DONE && !svc_cnt_bad && !svc_diff_q && elem_err_q
    |=> status1_o == 8'hFF && status2_o == 8'hA5)
    else $error("element error status wrong");
  chk_read_blocks: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == RFCPC_DONE && !is_write_q && !svc_cnt_bad && !svc_diff_q && !elem_err_q &&
    !mode_mixed_q && blk_cnt_q > (tunnel_q ? 5'h0F : 5'h0D) |=> status2_o == 8'hA2)
    else $error("read block limit missed");
  chk_write_blocks: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == RFCPC_DONE && is_write_q && !svc_cnt_bad && !svc_diff_q && !elem_err_q &&
    !mode_mixed_q && blk_cnt_q > (svc_cnt_q <= 5'h08 ? 5'h0C : 5'h0B)
    |=> status1_o == 8'hFF && status2_o == 8'hA2)
    else $error("write block limit missed");
endmodule

// ===== common/rfcpc_params.svh
// Constants for the RF command-parameter checker
`ifndef RFCPC_PARAMS_SVH
`define RFCPC_PARAMS_SVH
// ----------------------------------------
// System code matching
// ----------------------------------------
`define RFCPC_SC_WILDCARD 16'hFFFF
`define RFCPC_SC_PARTIAL 16'hAAFF
`define RFCPC_SC_UPPER 8'hAA
// ----------------------------------------
// Response-time descriptor fixed bytes and answer slot
// ----------------------------------------
`define RFCPC_DESC_ONES 8'hFF
`define RFCPC_DESC_ZERO 8'h00
`define RFCPC_FIRST_SLOT 8'h00
// ----------------------------------------
// Response-time parameter fields
// ----------------------------------------
`define RFCPC_RT_EXP_HI 7
`define RFCPC_RT_EXP_LO 6
`define RFCPC_RT_MUL_HI 5
`define RFCPC_RT_MUL_LO 3
`define RFCPC_RT_CON_HI 2
`define RFCPC_RT_CON_LO 0
// ----------------------------------------
// Block element fields
// ----------------------------------------
`define RFCPC_ACC_HI 6
`define RFCPC_ACC_LO 4
`define RFCPC_D2_RSV_HI 7
`define RFCPC_D2_RSV_LO 3
`define RFCPC_MODE_RF 3'h0
`define RFCPC_MODE_TUNNEL 3'h4
// ----------------------------------------
// Count limits
// ----------------------------------------
`define RFCPC_MAX_SVC_READ 5'h0F
`define RFCPC_MAX_SVC_WRITE 5'h0B
`define RFCPC_WR_SVC_SPLIT 5'h08
`define RFCPC_MAX_BLK_RD_RF 5'h0D
`define RFCPC_MAX_BLK_RD_TUN 5'h0F
`define RFCPC_MAX_BLK_WR_LO 5'h0C
`define RFCPC_MAX_BLK_WR_HI 5'h0B
`define RFCPC_CNT_SAT 5'h1F
// ----------------------------------------
// Status flag pairs
// ----------------------------------------
`define RFCPC_ST1_OK 8'h00
`define RFCPC_ST1_ERR 8'hFF
`define RFCPC_ST2_OK 8'h00
`define RFCPC_ST2_SVC_CNT 8'hA1
`define RFCPC_ST2_BLK_CNT 8'hA2
`define RFCPC_ST2_SVC_DIFF 8'hA3
`define RFCPC_ST2_BLK_SPEC 8'hA5
`endif

// ===== common/rfcpc_pkg.sv
// Types for the RF command-parameter checker
package rfcpc_pkg;
  typedef enum logic [1:0] {
    RFCPC_IDLE = 2'h0,
    RFCPC_SVC = 2'h1,
    RFCPC_BLK = 2'h3,
    RFCPC_DONE = 2'h2
  } rfcpc_state_t;
endpackage

// ===== hw/rfcpc_elem_dec.sv
// Block element decoder: access mode, reserved bits and communication mode
`timescale 1ns/1ns
`include "rfcpc_params.svh"
module rfcpc_elem_dec
  import rfcpc_pkg::*;
(
  // Element bytes
  input wire logic len3_i,
  input wire logic [7:0] byte0_i,
  input wire logic [7:0] byte2_i,
  // Decode
  output logic err_o,
  output logic tunnel_o
);
  logic acc_bad;
  logic rsv_bad;
  logic mode_bad;
  logic [2:0] mode;

  always_comb begin
    mode = len3_i ? byte2_i[2:0] : `RFCPC_MODE_RF;
    acc_bad = byte0_i[`RFCPC_ACC_HI:`RFCPC_ACC_LO] != 3'h0;
    rsv_bad = len3_i && (byte2_i[`RFCPC_D2_RSV_HI:`RFCPC_D2_RSV_LO] != 5'h00);
    mode_bad = (mode != `RFCPC_MODE_RF) && (mode != `RFCPC_MODE_TUNNEL);
    tunnel_o = mode == `RFCPC_MODE_TUNNEL;
    err_o = acc_bad || rsv_bad || mode_bad;
  end
endmodule

// ===== testbench/rfcpc_reader.sv
// Reader/writer model that issues identification requests and parameter lists
`timescale 1ns/1ns
module rfcpc_reader (
  // Clock
  input wire logic clk_i,
  // Identification request
  output logic req_valid_o,
  output logic [15:0] req_system_code_o,
  // Parameter list
  output logic cmd_start_o,
  output logic cmd_is_write_o,
  output logic svc_valid_o,
  output logic [15:0] svc_code_o,
  output logic blk_valid_o,
  output logic blk_len3_o,
  output logic [7:0] blk_byte0_o,
  output logic [7:0] blk_byte1_o,
  output logic [7:0] blk_byte2_o,
  output logic cmd_end_o
);
  initial begin
    {req_valid_o, req_system_code_o, cmd_start_o, cmd_is_write_o} = '0;
    {svc_valid_o, svc_code_o, blk_valid_o, blk_len3_o} = '0;
    {blk_byte0_o, blk_byte1_o, blk_byte2_o, cmd_end_o} = '0;
  end
  // ----------------------------------------
  // Requests
  // ----------------------------------------
  // Released lines carry the inverse, so a stale value never looks like data
  task automatic send_req(input logic [15:0] code);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_system_code_o <= code;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_system_code_o <= ~code;
  endtask
  // List lengths are the caller's, so refusals can be provoked on purpose
  task automatic send_list(input logic wr, input logic [15:0] s[$], input logic [24:0] b[$]);
    @(posedge clk_i);
    cmd_start_o <= 1'b1;
    cmd_is_write_o <= wr;
    @(posedge clk_i);
    cmd_start_o <= 1'b0;
    cmd_is_write_o <= ~wr;
    foreach (s[i]) begin
      svc_valid_o <= 1'b1;
      svc_code_o <= s[i];
      @(posedge clk_i);
    end
    svc_valid_o <= 1'b0;
    svc_code_o <= ~svc_code_o;
    foreach (b[i]) begin
      blk_valid_o <= 1'b1;
      {blk_len3_o, blk_byte0_o, blk_byte1_o, blk_byte2_o} <= b[i];
      @(posedge clk_i);
    end
    blk_valid_o <= 1'b0;
    {blk_byte0_o, blk_byte1_o, blk_byte2_o} <= ~{blk_byte0_o, blk_byte1_o, blk_byte2_o};
    cmd_end_o <= 1'b1;
    @(posedge clk_i);
    cmd_end_o <= 1'b0;
  endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking testbench of the RF command-parameter checker
`timescale 1ns/1ns
module testbench;
  logic clk_i = 1'b0, reset_n_i = 1'b0;
  logic [15:0] stored_system_code_i = 16'h0000;
  logic [63:0] card_identifier_area_i = 64'h0;
  logic [7:0] response_time_params_rd_i = 8'h00, response_time_params_wr_i = 8'h00;
  logic req_valid_i, cmd_start_i, cmd_is_write_i, svc_valid_i, blk_valid_i, blk_len3_i;
  logic cmd_end_i, id_resp_valid_o, blk_out_valid_o, blk_out_tunnel_o, blk_out_err_o;
  logic result_valid_o, busy_o;
  logic [15:0] req_system_code_i, svc_code_i, last_st = 16'h0000, st, rq;
  logic [7:0] blk_byte0_i, blk_byte1_i, blk_byte2_i, id_resp_slot_o, blk_out_number_o;
  logic [7:0] status1_o, status2_o;
  logic [63:0] id_resp_card_id_o, id_resp_time_desc_o;
  logic [1:0] rt_exp_o;
  logic [2:0] rt_mul_o, rt_const_o;
  logic [31:0] seed = 32'h020EEF97, r;
  logic [24:0] exp_blk[$], e_m;
  int n_fail = 0, checks = 0;
  always #25 clk_i = ~clk_i;
  rfcpc_reader i_rdr (.clk_i(clk_i), .req_valid_o(req_valid_i),
    .req_system_code_o(req_system_code_i), .cmd_start_o(cmd_start_i),
    .cmd_is_write_o(cmd_is_write_i), .svc_valid_o(svc_valid_i), .svc_code_o(svc_code_i),
    .blk_valid_o(blk_valid_i), .blk_len3_o(blk_len3_i), .blk_byte0_o(blk_byte0_i),
    .blk_byte1_o(blk_byte1_i), .blk_byte2_o(blk_byte2_i), .cmd_end_o(cmd_end_i));
  rfcpc_checker i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .stored_system_code_i(stored_system_code_i), .card_identifier_area_i(card_identifier_area_i),
    .response_time_params_rd_i(response_time_params_rd_i),
    .response_time_params_wr_i(response_time_params_wr_i), .req_valid_i(req_valid_i),
    .req_system_code_i(req_system_code_i), .id_resp_valid_o(id_resp_valid_o),
    .id_resp_slot_o(id_resp_slot_o), .id_resp_card_id_o(id_resp_card_id_o),
    .id_resp_time_desc_o(id_resp_time_desc_o), .cmd_start_i(cmd_start_i),
    .cmd_is_write_i(cmd_is_write_i), .svc_valid_i(svc_valid_i), .svc_code_i(svc_code_i),
    .blk_valid_i(blk_valid_i), .blk_len3_i(blk_len3_i), .blk_byte0_i(blk_byte0_i),
    .blk_byte1_i(blk_byte1_i), .blk_byte2_i(blk_byte2_i), .cmd_end_i(cmd_end_i),
    .blk_out_valid_o(blk_out_valid_o), .blk_out_number_o(blk_out_number_o),
    .blk_out_tunnel_o(blk_out_tunnel_o), .blk_out_err_o(blk_out_err_o), .rt_exp_o(rt_exp_o),
    .rt_mul_o(rt_mul_o), .rt_const_o(rt_const_o), .result_valid_o(result_valid_o),
    .status1_o(status1_o), .status2_o(status2_o), .busy_o(busy_o));
  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic sc_match(input logic [15:0] s, input logic [15:0] q);
    if (q == 16'hFFFF) return 1'b1;
    if (q == 16'hAAFF) return s[15:8] == 8'hAA;
    return s == q;
  endfunction
  // Element packed as {three-byte flag, D0, D1, D2}
  function automatic logic el_err(input logic [24:0] e);
    return e[22:20] != 3'h0 || (e[24] && (e[7:3] != 5'h00 || (e[2:0] != 3'h0 && e[2:0] != 3'h4)));
  endfunction
  function automatic logic el_tun(input logic [24:0] e);
    return e[24] && e[7:0] == 8'h04;
  endfunction
  // Reader's longest wait in units of T for n blocks, from one parameter byte
  function automatic int wait_t(input logic [7:0] p, input int n);
    return ((p[5:3] + 1) * n + p[2:0] + 1) << (2 * p[7:6]);
  endfunction
  function automatic logic [15:0] exp_status(input logic wr, input logic [15:0] s[$],
                                             input logic [24:0] b[$]);
    int lim;
    logic bad;
    if (s.size() == 0 || s.size() > (wr ? 11 : 15)) return 16'hFFA1;
    foreach (s[i]) if (s[i] != s[0]) return 16'hFFA3;
    bad = 1'b0;
    foreach (b[i]) if (el_err(b[i]) || el_tun(b[i]) != el_tun(b[0])) bad = 1'b1;
    if (bad) return 16'hFFA5;
    lim = wr ? (s.size() <= 8 ? 12 : 11) : (b.size() > 0 && el_tun(b[0]) ? 15 : 13);
    if (b.size() == 0 || b.size() > lim) return 16'hFFA2;
    return 16'h0000;
  endfunction
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_req(input logic [15:0] s, input logic [15:0] q);
    logic [31:0] x;
    x = rnd();
    @(posedge clk_i);
    stored_system_code_i <= s;
    card_identifier_area_i <= {rnd(), rnd()};
    {response_time_params_rd_i, response_time_params_wr_i} <= x[15:0];
    i_rdr.send_req(q);
    // The answer stands for the one cycle after the request edge
    #1;
    check(id_resp_valid_o, sc_match(s, q), "answer presence");
    if (sc_match(s, q)) begin
      check(id_resp_card_id_o, card_identifier_area_i, "card identifier");
      check(id_resp_time_desc_o, {40'hFFFF000000, response_time_params_rd_i,
            response_time_params_wr_i, 8'hFF}, "time descriptor");
      check(id_resp_slot_o, 8'h00, "slot");
    end
  endtask
  task automatic do_cmd(input logic wr, input int ns, input int nd, input int nb,
                        input logic tun, input logic [24:0] bad);
    logic [15:0] s[$];
    logic [24:0] b[$];
    logic [15:0] code;
    logic [31:0] x;
    x = rnd();
    code = x[15:0];
    for (int i = 0; i < ns; i++) s.push_back(i == nd ? ~code : code);
    for (int i = 0; i < nb; i++) begin
      x = rnd();
      b.push_back({tun | x[16], x[7:0] & 8'h8F, x[15:8], tun ? 8'h04 : 8'h00});
      if (bad != 25'h0 && i == nb - 1) b[i] = bad;
      exp_blk.push_back(b[i]);
    end
    check({status1_o, status2_o}, last_st, "status held");
    x = rnd();
    @(posedge clk_i);
    {response_time_params_rd_i, response_time_params_wr_i} <= x[15:0];
    i_rdr.send_list(wr, s, b);
    @(posedge clk_i);
    #1;
    last_st = exp_status(wr, s, b);
    check(result_valid_o, 1'b1, "result present");
    check(busy_o, 1'b1, "busy with result");
    check({status1_o, status2_o}, last_st, "status pair");
    @(posedge clk_i);
    #1;
    check(busy_o, 1'b0, "busy released");
    check({rt_exp_o, rt_mul_o, rt_const_o}, wr ? response_time_params_wr_i
          : response_time_params_rd_i, "time fields");
    check(wait_t({rt_exp_o, rt_mul_o, rt_const_o}, nb), wait_t(wr ? response_time_params_wr_i
          : response_time_params_rd_i, nb), "wait span");
    check(exp_blk.size(), 0, "elements answered");
  endtask
  // Each decoded element is compared with the oldest one sent
  always @(negedge clk_i) begin
    if (blk_out_valid_o === 1'b1) begin
      e_m = exp_blk.pop_front();
      check(blk_out_number_o, e_m[15:8], "block number");
      check(blk_out_err_o, el_err(e_m), "element error");
      if (!el_err(e_m)) check(blk_out_tunnel_o, el_tun(e_m), "tunnel mode");
    end
  end
  initial begin
    #3000000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check({status1_o, status2_o, result_valid_o, id_resp_valid_o}, 18'h0, "reset values");
    do_req(16'h1234, 16'hFFFF);
    do_req(16'hAA00, 16'hAAFF);
    do_req(16'hAB00, 16'hAAFF);
    do_req(16'h55AA, 16'h55AA);
    do_req(16'h55AA, 16'h55AB);
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      st = r[15:0];
      if (r[16]) st[15:8] = 8'hAA;
      case (r[18:17])
        2'h0: rq = 16'hFFFF;
        2'h1: rq = 16'hAAFF;
        2'h2: rq = st;
        default: rq = r[31:16];
      endcase
      do_req(st, rq);
    end
    $display("identification test ended");
    do_cmd(1'b0, 15, -1, 13, 1'b0, 25'h0);
    do_cmd(1'b0, 15, -1, 14, 1'b0, 25'h0);
    do_cmd(1'b0, 1, -1, 15, 1'b1, 25'h0);
    do_cmd(1'b0, 1, -1, 16, 1'b1, 25'h0);
    do_cmd(1'b1, 8, -1, 12, 1'b0, 25'h0);
    do_cmd(1'b1, 8, -1, 13, 1'b1, 25'h0);
    do_cmd(1'b1, 9, -1, 11, 1'b1, 25'h0);
    do_cmd(1'b1, 9, -1, 12, 1'b0, 25'h0);
    do_cmd(1'b1, 12, -1, 1, 1'b0, 25'h0);
    do_cmd(1'b0, 16, -1, 1, 1'b0, 25'h0);
    do_cmd(1'b0, 3, 1, 2, 1'b0, 25'h0);
    do_cmd(1'b0, 2, -1, 3, 1'b0, {1'b0, 8'h90, 8'h05, 8'h00});
    do_cmd(1'b1, 2, -1, 3, 1'b1, {1'b1, 8'h80, 8'h05, 8'h0C});
    for (int m = 1; m < 8; m++) do_cmd(1'b0, 1, -1, 2, 1'b0, {17'h1_0007, 5'h00, m[2:0]});
    $display("corner command test ended");
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      do_cmd(r[0], r[8:4] % 17, r[2] ? r[10:9] : -1, r[15:11] % 17, r[1],
             r[3] ? {r[16], r[31:8]} : 25'h0);
    end
    $display("random command test ended");
    conclude();
  end
endmodule
